// >>> pcbd_pkg.sv
/*
 pcbd_pkg: constants, register map and types for the pll clock bank divider.
 Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
// Functional notes
// RULE_01: derive half and quarter clocks, 50% duty
// RULE_02: select code adds quarter banks one to three
// RULE_03: three selectable banks of three outputs
// RULE_04: fourth bank always carries half clock
// RULE_05: disabled outputs are held low
// RULE_06: clear falling edge resets quarter stage
// RULE_07: board ties clear input to fixed level
// RULE_08: test mode bypasses the loop
// RULE_09: board keeps test low in normal use
// RULE_10: board feeds back exactly one output
// RULE_11: half output fed back runs oscillator double
// RULE_12: quarter output fed back gives double outputs
// RULE_13: half feedback needs reference 50 to 100 MHz
// RULE_14: quarter feedback needs reference 25 to 50 MHz
// RULE_15: outputs keep 50% duty regardless of input
// RULE_16: users wait lock time after disturbances
// RULE_17: reference must be fixed frequency and phase
// RULE_18: loop drives feedback phase offset to zero
// RULE_19: lock counter restarts on disturbance, reports unlocked
package pcbd_pkg;

	localparam int          CLK_MHZ       = 50;
	localparam int          CLK_PERIOD_NS = 20;

	localparam int          ADDR_W = 4;
	localparam int          DATA_W = 32;

	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h4;
	localparam logic [3:0]  REG_PERIOD = 4'h8;
	localparam logic [3:0]  REG_MEAS   = 4'hc;

	localparam int          CTRL_W       = 4;
	localparam int          CTRL_SEL_LSB = 0;
	localparam int          CTRL_SEL_MSB = 1;
	localparam int          CTRL_OE_N    = 2;
	localparam int          CTRL_TEST    = 3;
	localparam logic [3:0]  CTRL_RESET   = 4'h4;

	localparam int          STAT_LOCKED  = 0;
	localparam int          STAT_BYPASS  = 1;
	localparam int          STAT_ALIGNED = 2;
	localparam int          STAT_STATE   = 4;

	localparam int          LOCK_TIME_US = 100;
	localparam int unsigned LOCK_CYC     = LOCK_TIME_US * CLK_MHZ;

	localparam int          PER_W         = 8;
	localparam logic [7:0]  OSC_HALF_INIT = 8'h04;
	localparam logic [7:0]  OSC_HALF_MIN  = 8'h00;
	localparam logic [7:0]  OSC_HALF_MAX  = 8'hff;
	localparam int          MEAS_W        = 16;
	localparam int          MEAS_HI       = 16;

	localparam int          NUM_BANKS = 4;
	localparam int          BANK_OUTS = 3;
	localparam int          SEL_BANKS = 3;

	typedef enum logic [1:0] {
		LOOP_ACQ,
		LOOP_TRACK,
		LOOP_BYPASS
	} pcbd_loop_t;

endpackage : pcbd_pkg

// >>> pcbd_core_if.sv
/*
 pcbd_core_if: carries divider and lock-timer signals between the top and
 its two helpers. Assumes all users sit on the one system clock.
*/
`timescale 1ns/100ps
interface pcbd_core_if;
	logic tick;
	logic quarter_clear;
	logic ref_half;
	logic ref_quarter;
	logic restart;
	logic locked;

	modport core (output tick, quarter_clear, restart, input ref_half, ref_quarter, locked);
	modport div  (input tick, quarter_clear, output ref_half, ref_quarter);
	modport lock (input restart, output locked);
endinterface : pcbd_core_if

// >>> pcbd_divider.sv
/*
 pcbd_divider: oscillator tick divided into half and quarter references.
 Assumes tick is a one-cycle pulse per oscillator period, on clk.
*/
`timescale 1ns/100ps
module pcbd_divider
	import pcbd_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	pcbd_core_if.div core
);
	logic [1:0] div_q;
	logic [1:0] div_d;

	// one binary counter: bit0 toggles each tick, bit1 every second tick
	always_comb begin
		div_d = div_q;
		if (core.tick)
			div_d = div_q + 2'h1; // RULE_01 RULE_15
		if (core.quarter_clear)
			div_d[1] = 1'b0; // RULE_06
	end

	always_ff @(posedge clk) begin
		if (rst)
			div_q <= 2'h0;
		else
			div_q <= div_d;
	end

	assign core.ref_half    = div_q[0];
	assign core.ref_quarter = div_q[1];
endmodule : pcbd_divider

// >>> pcbd_lock_timer.sv
/*
 pcbd_lock_timer: counts the lock wait after each disturbance.
 Assumes restart is a level or pulse on clk; holding it keeps lock low.
*/
`timescale 1ns/100ps
module pcbd_lock_timer
	import pcbd_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = LOCK_CYC
)(
	input wire logic clk,
	input wire logic rst,
	pcbd_core_if.lock core
);
	localparam int            CNT_W = $clog2(LOCK_CYCLES + 1);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(LOCK_CYCLES - 1);

	if (LOCK_CYCLES < 1) begin : g_bad_cycles
		$error("lock wait must be at least one cycle");
	end

	logic [CNT_W-1:0] cnt_q;
	logic             locked_q;

	always_ff @(posedge clk) begin
		if (rst || core.restart) begin
			cnt_q    <= '0; // RULE_19
			locked_q <= 1'b0;
		end else if (!locked_q) begin
			if (cnt_q == LAST)
				locked_q <= 1'b1; // RULE_19
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end

	assign core.locked = locked_q;
endmodule : pcbd_lock_timer

// >>> pcbd_top.sv
/*
 pcbd_top: digital model of a phase-locked clock driver with four banks of
 three outputs, a register port and a lock-wait timer.
 Assumes the reference, feedback and clear pins are asynchronous to clk and
 much slower than it; one output is wired back to the feedback pin.
*/
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module pcbd_top
	import pcbd_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = LOCK_CYC,
	parameter logic [7:0]  HALF_INIT   = OSC_HALF_INIT
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_we,
	input  wire logic              reg_re,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              ref_clock_input,
	input  wire logic              loop_feedback_input,
	input  wire logic              quarter_divider_clear_n,
	output logic      [2:0]        bank_one_clocks,
	output logic      [2:0]        bank_two_clocks,
	output logic      [2:0]        bank_three_clocks,
	output logic      [2:0]        bank_four_clocks,
	output logic                   lock_status
);
	if (LOCK_CYCLES < 1) begin : g_bad_lock
		$error("lock wait must be at least one cycle");
	end
	if (NUM_BANKS * BANK_OUTS != 12) begin : g_bad_banks
		$error("bank layout must give twelve outputs");
	end

	pcbd_core_if core_if ();

	// pin synchronisers: index 0 ref, 1 feedback, 2 clear
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [2:0] pin_prev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_prev_q <= 3'h0;
		end else begin
			pin_meta_q <= {quarter_divider_clear_n, loop_feedback_input, ref_clock_input};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	wire ref_rise = pin_sync_q[0] & ~pin_prev_q[0];
	wire fb_rise  = pin_sync_q[1] & ~pin_prev_q[1];
	wire clr_fall = ~pin_sync_q[2] & pin_prev_q[2];

	// control register
	logic [CTRL_W-1:0] ctrl_q;

	wire             ctrl_wr  = reg_we && (reg_addr == REG_CTRL);
	wire [CTRL_W-1:0] ctrl_new = reg_wdata[CTRL_W-1:0];
	wire [1:0]       sel      = {ctrl_q[CTRL_SEL_MSB], ctrl_q[CTRL_SEL_LSB]};
	wire             oe_n     = ctrl_q[CTRL_OE_N];
	wire             test     = ctrl_q[CTRL_TEST];

	always_ff @(posedge clk) begin
		if (rst)
			ctrl_q <= CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= ctrl_new;
	end

	// disturbances that force a fresh lock wait
	wire sel_change = ctrl_wr && (ctrl_new[CTRL_SEL_MSB:CTRL_SEL_LSB] != sel);
	wire loop_on    = ctrl_wr && test && !ctrl_new[CTRL_TEST];
	wire outs_on    = ctrl_wr && oe_n && !ctrl_new[CTRL_OE_N];
	wire ctrl_event = sel_change || loop_on || outs_on; // RULE_19

	// loop state
	pcbd_loop_t state_q;
	pcbd_loop_t state_d;

	// period and phase measurement in clk cycles
	logic [MEAS_W-1:0] ref_run_q;
	logic [MEAS_W-1:0] fb_run_q;
	logic [MEAS_W-1:0] ref_per_q;
	logic [MEAS_W-1:0] fb_per_q;
	logic [MEAS_W-1:0] phase_q;
	logic [1:0]        ref_seen_q;
	logic [1:0]        fb_seen_q;
	logic              aligned_q;

	wire meas_ok = ref_seen_q[1] && fb_seen_q[1];
	wire [MEAS_W-1:0] ref_run_inc = (&ref_run_q) ? ref_run_q : ref_run_q + 1'b1;
	wire [MEAS_W-1:0] fb_run_inc  = (&fb_run_q) ? fb_run_q : fb_run_q + 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			ref_run_q  <= '0;
			fb_run_q   <= '0;
			ref_per_q  <= '0;
			fb_per_q   <= '0;
			phase_q    <= '0;
			ref_seen_q <= 2'h0;
			fb_seen_q  <= 2'h0;
		end else begin
			ref_run_q <= ref_rise ? '0 : ref_run_inc;
			fb_run_q  <= fb_rise ? '0 : fb_run_inc;
			if (ref_rise) begin
				ref_per_q  <= ref_run_inc;
				ref_seen_q <= {ref_seen_q[0], 1'b1};
			end
			if (fb_rise) begin
				fb_per_q  <= fb_run_inc;
				fb_seen_q <= {fb_seen_q[0], 1'b1};
				phase_q   <= ref_rise ? '0 : ref_run_inc;
			end
		end
	end

	// oscillator: one tick every half_q+1 clocks
	logic [PER_W-1:0] half_q;
	logic [PER_W-1:0] half_d;
	logic [PER_W-1:0] osc_q;
	logic             adv_q;
	logic             hold_q;
	logic [1:0]       fresh_q;

	// feedback periods measured across a trim or nudge are not trusted,
	// else the trim chases its own lag and the loop never settles
	wire settled   = (fresh_q == 2'h0);
	wire tracking  = (state_q == LOOP_TRACK);
	wire freq_eval = tracking && ref_rise && meas_ok && settled;
	wire fb_slow   = fb_per_q > ref_per_q;
	wire fb_fast   = fb_per_q < ref_per_q;
	wire go_faster = freq_eval && fb_slow && (half_q != OSC_HALF_MIN);
	wire go_slower = freq_eval && fb_fast && (half_q != OSC_HALF_MAX);

	// phase nudge only once the frequencies agree, else it fights the trim
	wire same_freq = meas_ok && (fb_per_q == ref_per_q);
	wire ph_eval   = tracking && fb_rise && !ref_rise && same_freq && settled;
	wire fb_lags   = ref_run_inc < (ref_per_q >> 1);
	wire nudge_adv  = ph_eval && fb_lags; // RULE_18
	wire nudge_hold = ph_eval && !fb_lags; // RULE_18

	always_comb begin
		half_d = half_q;
		if (go_faster)
			half_d = half_q - 1'b1; // RULE_11 RULE_12
		else if (go_slower)
			half_d = half_q + 1'b1; // RULE_11 RULE_12
	end

	wire             osc_wrap = (osc_q >= half_q);
	wire [PER_W:0]   osc_step = {1'b0, osc_q} + (adv_q ? 9'h002 : 9'h001);
	wire [PER_W-1:0] osc_next = osc_step[PER_W] ? half_q : osc_step[PER_W-1:0];

	// two feedback rises clear it: the spoilt period, then a clean one
	wire       loop_fix = go_faster || go_slower || nudge_adv || nudge_hold;
	wire [1:0] fresh_d  = loop_fix ? 2'h2 : (fb_rise && !settled) ? fresh_q - 2'h1 : fresh_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			half_q  <= HALF_INIT;
			osc_q   <= '0;
			adv_q   <= 1'b0;
			hold_q  <= 1'b0;
			fresh_q <= 2'h0;
		end else begin
			half_q  <= half_d;
			fresh_q <= fresh_d; // RULE_18
			adv_q  <= nudge_adv;
			hold_q <= nudge_hold;
			if (osc_wrap)
				osc_q <= '0;
			else if (!hold_q)
				osc_q <= osc_next;
		end
	end

	// in test mode the reference itself clocks the dividers
	wire bypass = (state_q == LOOP_BYPASS);
	assign core_if.tick          = bypass ? ref_rise : osc_wrap; // RULE_08
	assign core_if.quarter_clear = clr_fall; // RULE_06

	// aligned when both edges land in the same cycle
	always_ff @(posedge clk) begin
		if (rst)
			aligned_q <= 1'b0;
		else if (fb_rise)
			aligned_q <= ref_rise; // RULE_18
		else if (ref_rise && fb_seen_q[0] && ref_run_q > ref_per_q)
			aligned_q <= 1'b0;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			LOOP_ACQ: begin
				if (test)
					state_d = LOOP_BYPASS; // RULE_08
				else if (meas_ok)
					state_d = LOOP_TRACK;
			end
			LOOP_TRACK: begin
				if (test)
					state_d = LOOP_BYPASS; // RULE_08
			end
			LOOP_BYPASS: begin
				if (!test)
					state_d = LOOP_ACQ;
			end
			default: state_d = LOOP_ACQ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state_q <= LOOP_ACQ;
		else
			state_q <= state_d;
	end

	// lock timer restarts on every disturbance and every loop correction
	wire loop_moved = go_faster || go_slower || nudge_adv || nudge_hold;
	wire not_ready  = (state_q != LOOP_TRACK) || oe_n;
	assign core_if.restart = ctrl_event || loop_moved || clr_fall || not_ready; // RULE_19

	pcbd_divider u_divider (
		.clk  (clk),
		.rst  (rst),
		.core (core_if.div)
	);

	pcbd_lock_timer #(
		.LOCK_CYCLES (LOCK_CYCLES)
	) u_lock (
		.clk  (clk),
		.rst  (rst),
		.core (core_if.lock)
	);

	// bank steering: bank b (0..2) takes the quarter clock when sel > b
	logic [NUM_BANKS*BANK_OUTS-1:0] bank_q;
	wire  [NUM_BANKS*BANK_OUTS-1:0] bank_d;
	wire  [NUM_BANKS-1:0]           use_quarter;

	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		if (b < SEL_BANKS) begin : g_sel
			assign use_quarter[b] = (sel > 2'(b)); // RULE_02 RULE_03
		end else begin : g_fixed
			assign use_quarter[b] = 1'b0; // RULE_04
		end
		wire src = use_quarter[b] ? core_if.ref_quarter : core_if.ref_half;
		assign bank_d[b*BANK_OUTS +: BANK_OUTS] = oe_n ? '0 : {BANK_OUTS{src}}; // RULE_05
	end

	always_ff @(posedge clk) begin
		if (rst)
			bank_q <= '0;
		else
			bank_q <= bank_d;
	end

	assign bank_one_clocks   = bank_q[0*BANK_OUTS +: BANK_OUTS];
	assign bank_two_clocks   = bank_q[1*BANK_OUTS +: BANK_OUTS];
	assign bank_three_clocks = bank_q[2*BANK_OUTS +: BANK_OUTS];
	assign bank_four_clocks  = bank_q[3*BANK_OUTS +: BANK_OUTS];

	logic lock_q;

	always_ff @(posedge clk) begin
		if (rst)
			lock_q <= 1'b0;
		else
			lock_q <= core_if.locked; // RULE_19
	end

	assign lock_status = lock_q;

	// register read port: data in the cycle after the strobe only
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rd_mux;

	wire [DATA_W-1:0] status_word = {
		{(DATA_W-STAT_STATE-2){1'b0}},
		state_q,
		1'b0,
		aligned_q,
		bypass,
		lock_q
	};

	always_comb begin
		case (reg_addr)
			REG_CTRL:   rd_mux = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
			REG_STATUS: rd_mux = status_word;
			// upper half: feedback-to-reference phase, for debug
			REG_PERIOD: rd_mux = {phase_q, {(MEAS_W-PER_W){1'b0}}, half_q};
			REG_MEAS:   rd_mux = {fb_per_q, ref_per_q};
			default:    rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			rdata_q <= '0;
		else if (reg_re)
			rdata_q <= rd_mux;
		else
			rdata_q <= '0;
	end

	assign reg_rdata = rdata_q;
endmodule : pcbd_top

// >>> pcbd_top_asserts.sv
/*
 pcbd_top_asserts: port-level checks of the clock bank divider.
 Assumes it is bound into pcbd_top and that the clear pin is quiet outside its own test.
*/
`timescale 1ns/100ps
module pcbd_top_asserts
	import pcbd_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = LOCK_CYC,
	parameter logic [7:0]  HALF_INIT   = OSC_HALF_INIT
)(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_we,
	input wire logic              reg_re,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              ref_clock_input,
	input wire logic              loop_feedback_input,
	input wire logic              quarter_divider_clear_n,
	input wire logic [2:0]        bank_one_clocks,
	input wire logic [2:0]        bank_two_clocks,
	input wire logic [2:0]        bank_three_clocks,
	input wire logic [2:0]        bank_four_clocks,
	input wire logic              lock_status
);
	logic [3:0]  ctrl_q;
	logic [3:0]  calm_q;
	logic [31:0] since_q;
	logic        clr_q;
	logic        wr_ctrl;
	logic        calm;
	logic        live;
	logic [11:0] all_out;

	assign wr_ctrl = reg_we && reg_addr == REG_CTRL;
	// banks lag control and clear by a few cycles; judge only once settled
	assign calm    = calm_q >= 4'h8;
	assign live    = calm && !ctrl_q[CTRL_OE_N];
	assign all_out = {bank_one_clocks, bank_two_clocks, bank_three_clocks, bank_four_clocks};

	always_ff @(posedge clk) begin
		clr_q <= quarter_divider_clear_n;
		if (rst) begin
			ctrl_q  <= CTRL_RESET;
			calm_q  <= 4'h0;
			since_q <= 32'h0;
		end else begin
			if (wr_ctrl) ctrl_q <= reg_wdata[3:0];
			calm_q  <= (wr_ctrl || clr_q != quarter_divider_clear_n) ? 4'h0 : calm_q + {3'h0, ~&calm_q};
			since_q <= (wr_ctrl && reg_wdata[3:0] != ctrl_q) ? 32'h0 : since_q + {31'h0, ~&since_q};
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence off_write_s;
		wr_ctrl && reg_wdata[CTRL_OE_N] ##1 !wr_ctrl;
	endsequence

	out_dark_a: assert property (off_write_s |=> (all_out == 12'h000)[*2])
		else $error("outputs not forced low after disable");
	dark_hold_a: assert property (calm && ctrl_q[CTRL_OE_N] |-> all_out == 12'h000)
		else $error("disabled outputs toggling");
	trio_same_a: assert property (bank_one_clocks inside {3'h0, 3'h7} && bank_two_clocks inside {3'h0, 3'h7} &&
		bank_three_clocks inside {3'h0, 3'h7} && bank_four_clocks inside {3'h0, 3'h7})
		else $error("outputs of one bank differ");
	bank_two_a: assert property (live |-> bank_two_clocks == (ctrl_q[1:0] >= 2'h2 ? bank_one_clocks : bank_four_clocks))
		else $error("bank two source wrong");
	bank_three_a: assert property (live |-> bank_three_clocks == (ctrl_q[1:0] == 2'h3 ? bank_one_clocks : bank_four_clocks)
		&& (ctrl_q[1:0] != 2'h0 || bank_one_clocks == bank_four_clocks))
		else $error("bank three or one source wrong");
	quarter_step_a: assert property (live && ctrl_q[1:0] != 2'h0 && $changed(bank_one_clocks) |-> $changed(bank_four_clocks))
		else $error("quarter moved without half");
	dis_unlock_a: assert property (calm && ctrl_q[CTRL_OE_N] |-> !lock_status)
		else $error("locked while disabled");
	test_unlock_a: assert property (calm && ctrl_q[CTRL_TEST] |-> !lock_status)
		else $error("locked in bypass");
	lock_wait_a: assert property ($rose(lock_status) |-> since_q >= LOCK_CYCLES)
		else $error("lock before wait ran out");
	rd_idle_a: assert property (!reg_re |=> reg_rdata == '0)
		else $error("read data outside read slot");
endmodule : pcbd_top_asserts

bind pcbd_top pcbd_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES), .HALF_INIT(HALF_INIT)) u_chk (.clk, .rst,
	.reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .ref_clock_input, .loop_feedback_input,
	.quarter_divider_clear_n, .bank_one_clocks, .bank_two_clocks, .bank_three_clocks,
	.bank_four_clocks, .lock_status);

// >>> pcbd_board.sv
/*
 pcbd_board: board around the divider: reference source and feedback strap.
 Assumes the bench picks the strapped output before each lock wait.
*/
`timescale 1ns/100ps
module pcbd_board #(
	// one steady rate standing in for the allowed band of either feedback
	parameter int REF_HALF_NS = 480
)(
	input  wire logic       fb_pick,
	input  wire logic [2:0] bank_one_clocks,
	input  wire logic [2:0] bank_four_clocks,
	output logic            ref_clock_input,
	output logic            loop_feedback_input
);
	// steady rate and phase, else the loop never settles
	initial begin
		ref_clock_input = 1'b0;
		forever #(REF_HALF_NS) ref_clock_input = ~ref_clock_input;
	end

	// one output strapped back; pick 1 takes a quarter output
	assign loop_feedback_input = fb_pick ? bank_one_clocks[0] : bank_four_clocks[0];
endmodule : pcbd_board

// >>> pcbd_top_tb.sv
/*
 pcbd_top_tb: register-driven tests of the clock bank divider.
 Assumes the board model supplies the reference and the feedback strap.
*/
`timescale 1ns/100ps
module pcbd_top_tb
	import pcbd_pkg::*;
;
	logic              clk;
	logic              rst;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_we;
	logic              reg_re;
	logic [DATA_W-1:0] reg_rdata;
	logic              ref_clock_input;
	logic              loop_feedback_input;
	logic              quarter_divider_clear_n;
	logic [2:0]        bank_one_clocks;
	logic [2:0]        bank_two_clocks;
	logic [2:0]        bank_three_clocks;
	logic [2:0]        bank_four_clocks;
	logic              lock_status;
	logic              fb_pick;
	logic [31:0]       d;
	int                errors;
	int                total_checks;
	int                c1;
	int                c4;
	int                cr;
	int                n;

	// lock wait spans several reference periods so a loop still trimming never reads as locked
	pcbd_top #(.LOCK_CYCLES(400)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
		.ref_clock_input, .loop_feedback_input, .quarter_divider_clear_n, .bank_one_clocks,
		.bank_two_clocks, .bank_three_clocks, .bank_four_clocks, .lock_status);
	pcbd_board board (.fb_pick, .bank_one_clocks, .bank_four_clocks, .ref_clock_input, .loop_feedback_input);

	task automatic finish_test;
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [31:0] near(input int a, input int b);
		return {31'h0, (a - b <= 2) && (b - a <= 2)};
	endfunction : near

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_we    <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_re   <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic wait_lock;
		n = 0;
		while (lock_status !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			finish_test();
		end
	endtask : wait_lock

	// toggle counts over twenty reference periods
	task automatic count;
		logic [2:0] p;
		logic [2:0] x;
		c1 = 0;
		c4 = 0;
		cr = 0;
		p = {ref_clock_input, bank_four_clocks[0], bank_one_clocks[0]};
		repeat (960) begin
			@(posedge clk);
			#1;
			x = p ^ {ref_clock_input, bank_four_clocks[0], bank_one_clocks[0]};
			p = p ^ x;
			c1 += x[0];
			c4 += x[1];
			cr += x[2];
		end
	endtask : count

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		quarter_divider_clear_n = 1'b1;
		fb_pick = 1'b0;
		errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wr(4'h2, 32'hffffffff);
		rd(4'h2, d);
		check("unmapped", d, 32'h0);
		rd(REG_CTRL, d);
		check("ctrl reset", d, {28'h0, CTRL_RESET});
		check("dark reset", {20'h0, bank_one_clocks, bank_two_clocks, bank_three_clocks, bank_four_clocks}, 32'h0);
		for (int s = 0; s < 4; s++) begin
			wr(REG_CTRL, 32'(s));
			repeat (4) @(posedge clk);
			check("restart", {31'h0, lock_status}, 32'h0);
			wait_lock();
			rd(REG_STATUS, d);
			check("status", d & 32'h37, 32'h15);
			count();
			check("half fed", near(c4, cr), 32'h1);
			check("bank one", {31'h0, c1 == c4}, {31'h0, s == 0});
			check("bank four", near(c4, 2 * c1), {31'h0, s != 0});
		end
		fb_pick <= 1'b1;
		repeat (400) @(posedge clk);
		wait_lock();
		count();
		check("quarter fed", near(c1, cr), 32'h1);
		check("double", near(c4, 2 * cr), 32'h1);
		n = 0;
		while (bank_one_clocks[0] !== 1'b0 && n < 200) begin
			@(posedge clk);
			n++;
		end
		while (bank_one_clocks[0] !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		check("rise wait", {31'h0, n < 200}, 32'h1);
		quarter_divider_clear_n <= 1'b0;
		repeat (8) @(posedge clk);
		check("clear", {29'h0, bank_one_clocks}, 32'h0);
		quarter_divider_clear_n <= 1'b1;
		wr(REG_CTRL, 32'h7);
		repeat (4) @(posedge clk);
		check("disable", {19'h0, bank_one_clocks, bank_two_clocks, bank_three_clocks, bank_four_clocks, lock_status}, 32'h0);
		fb_pick <= 1'b0;
		wr(REG_CTRL, 32'h8);
		repeat (4) @(posedge clk);
		rd(REG_STATUS, d);
		check("bypass", d & 32'h33, 32'h22);
		count();
		check("bypass rate", near(2 * c4, cr), 32'h1);
		wr(REG_CTRL, 32'h0);
		repeat (4) @(posedge clk);
		check("test exit", {31'h0, lock_status}, 32'h0);
		wait_lock();
		check("relock", {31'h0, lock_status}, 32'h1);
		finish_test();
	end
endmodule : pcbd_top_tb
